// >>> hw/cpm_defines.svh
/*
 Register offsets, field positions, reset values and counts of the
 clock and power-mode controller. Assumes word-aligned AHB-Lite access.
*/
// Functional notes
// - Synth reference: divided, crystal, low-power, rtc
// - Synth locks to any running reference
// - Software enable powers synth up/down
// - Synth output rate set by divider
// - Software keeps generated clocks under maximum
// - Main mux switches only when both toggle
// - Monitor divider halts and restarts cleanly
// - Synth outputs routable to monitor pin
// - Divided internal clock is fast/8
// - Rtc crystal tick needs enable bit
// - Every mux has tied-off none input
// - Brownout gives interrupt or reset request
// - Sleep gates core clocks until wake
// - Deep-sleep: flash off, only kept peripherals
// - Deep-sleep wake set is broad
// - Registers keep contents across low power
// - Power-down: converter off, four peripherals only
// - Power-down wake set is narrow
// - Primary core state retained in power-down
// - Deep power-down keeps rtc, pins, ostimer
// - Deep power-down wake: alarm, pins, ostimer
// - One-hertz alarm flag wakes deep power-down
// - Functional pins high-impedance in deep power-down
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH

// Register byte offsets
`define REG_MAIN_SEL 8'h00
`define REG_SYNTH0 8'h04
`define REG_SYNTH1 8'h08
`define REG_MONITOR 8'h0C
`define REG_PWR_CTRL 8'h10
`define REG_BOD_CTRL 8'h14
`define REG_RTC_OSC 8'h18
`define REG_STATUS 8'h1C

// Field positions
`define SYNTH_EN_BIT 3
`define MON_HALT_BIT 3
`define DIV_LSB 8
`define BOD_EN_BIT 0
`define BOD_RST_BIT 1
`define RTC_EN_BIT 0
`define RTC_ALARM_BIT 1
`define RTC_OSDPD_BIT 2

// Reset values
`define MAIN_SEL_RESET 3'h2
`define DIV_RESET 8'h00

// Counts
`define FAST_DIV_COUNT 8
`define LOCK_REFS 16

// Wake event bit numbers
`define WK_PIN 0
`define WK_GROUP 1
`define WK_TIMER 2
`define WK_OSTIMER 3
`define WK_RTC 4
`define WK_WDOG 5
`define WK_BOD 6
`define WK_USB 7
`define WK_SERIAL 8
`define WK_SERIAL3 9
`define WK_CMP 10
`define WK_LOGIC 11
`define WK_WAKEPIN 12
`define WK_IRQ 13

// Wake masks per mode
`define WAKE_SLEEP 14'h3FFF
`define WAKE_DEEP_SLEEP 14'h0FFF
`define WAKE_POWER_DOWN 14'h061A
`define WAKE_DEEP_PD 14'h1010
`define WAKE_DPD_OSTIMER 14'h0008

// Peripheral clock bits and per-mode allowance
`define PERIPH_PD_MASK 8'h5C
`define PERIPH_DPD_MASK 8'h08
`define PERIPH_OSTIMER 8'h10

`endif

// >>> hw/cpm_pkg.sv
/*
 Types of the clock and power-mode controller.
 Assumes cpm_defines.svh for numeric constants.
*/
package cpm_pkg;
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b000,
		MODE_SLEEP = 3'b001,
		MODE_DEEP_SLEEP = 3'b010,
		MODE_POWER_DOWN = 3'b011,
		MODE_DEEP_PD = 3'b100
	} pmode_t;

	// Clock source codes, code 0 is the tied-off input
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_FAST = 3'b001,
		SRC_DIVIDED = 3'b010,
		SRC_LOW_POWER = 3'b011,
		SRC_RTC = 3'b100,
		SRC_XTAL = 3'b101,
		SRC_SYNTH0 = 3'b110,
		SRC_SYNTH1 = 3'b111
	} src_t;

	typedef logic [13:0] wake_t;
endpackage

// >>> hw/cpm_if.sv
/*
 Link between the controller and the cores and peripherals it clocks.
 Assumes both ends share CLK_SYS; clock enables are one-cycle ticks.
*/
`timescale 1ns/1ps
interface cpm_if;
	logic [1:0] core_clk_en;
	logic [7:0] periph_clk_en;
	logic flash_pwr_on;
	logic dcdc_on;
	logic core_pwr_on;
	logic pins_hiz;
	logic primary_core_retain;
	cpm_pkg::pmode_t power_mode;
	logic bod_irq;
	cpm_pkg::wake_t wake_event;

	modport ctrl (
		output core_clk_en, periph_clk_en, flash_pwr_on, dcdc_on,
		output core_pwr_on, pins_hiz, primary_core_retain, power_mode, bod_irq,
		input wake_event
	);
	modport cons (
		input core_clk_en, periph_clk_en, flash_pwr_on, dcdc_on,
		input core_pwr_on, pins_hiz, primary_core_retain, power_mode, bod_irq,
		output wake_event
	);
endinterface

// >>> hw/cpm_consumer.sv
/*
 Cores and peripherals end: counts gated core ticks, forwards wake
 events and drives a functional pin. Assumes the controller on cpm_if.
*/
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_consumer (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Controller link
	cpm_if.cons lnk,
	// User side
	input wire cpm_pkg::wake_t WAKE_REQ,
	input wire logic PIN_DRIVE,
	input wire logic PIN_DIR,
	output logic PIN_OUT,
	output logic PIN_OE,
	output logic [15:0] CORE0_TICKS,
	output logic [15:0] CORE1_TICKS,
	output logic [7:0] PERIPH_TICKED,
	output logic BOD_IRQ_SEEN
);
	import cpm_pkg::*;

	// Wake events forwarded as registered pulses or levels
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			lnk.wake_event <= '0;
		end else begin
			lnk.wake_event <= WAKE_REQ;
		end
	end

	// Core work advances only on its tick, state is cleared only by reset
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			CORE0_TICKS <= 16'h0000;
			CORE1_TICKS <= 16'h0000;
		end else begin
			if (lnk.core_clk_en[0]) begin
				CORE0_TICKS <= CORE0_TICKS + 16'h0001;
			end
			if (lnk.core_clk_en[1]) begin
				CORE1_TICKS <= CORE1_TICKS + 16'h0001;
			end
		end
	end

	// Peripheral tick monitor and brownout interrupt capture
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			PERIPH_TICKED <= 8'h00;
			BOD_IRQ_SEEN <= 1'b0;
		end else begin
			PERIPH_TICKED <= lnk.periph_clk_en;
			BOD_IRQ_SEEN <= lnk.bod_irq;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			PIN_OUT <= 1'b0;
			PIN_OE <= 1'b0;
		end else begin
			PIN_OUT <= PIN_DRIVE;
			PIN_OE <= PIN_DIR & ~lnk.pins_hiz;
		end
	end
endmodule

// >>> hw/cpm_controller.sv
/*
 Clock source selection, synthesizers, clock monitor divider,
 brownout response and power-mode sequencing, with an AHB-Lite slave.
 Assumes source oscillators arrive as one-cycle ticks on CLK_SYS.
*/
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_controller #(
	parameter int LOCK_REFS = `LOCK_REFS
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Oscillator ticks
	input wire logic FAST_OSC_TICK,
	input wire logic XTAL_TICK,
	input wire logic LP_OSC_TICK,
	input wire logic RTC_XTAL_TICK,
	// Brownout and monitor pin
	input wire logic BOD_LOW,
	output logic BOD_RESET_REQ,
	output logic CLOCK_MONITOR_PIN,
	// Consumer link
	cpm_if.ctrl lnk
);
	import cpm_pkg::*;

	logic wr_pend;
	logic [7:0] wr_addr;
	logic rd_go;
	src_t main_req;
	src_t main_cur;
	logic seen_old;
	logic [2:0] synth_ref [2];
	logic [1:0] synth_en;
	logic [7:0] synth_div [2];
	logic [1:0] synth_lock;
	logic [1:0] synth_out;
	src_t mon_sel;
	logic mon_halt;
	logic [7:0] mon_div;
	logic [7:0] mon_cnt;
	logic [7:0] keep_mask;
	logic bod_en;
	logic bod_rst_mode;
	logic rtc_en;
	logic alarm_flag;
	logic os_dpd_en;
	pmode_t mode;
	wake_t wake_cause;
	logic mode_req;
	logic [2:0] fast_cnt;
	logic div_tick;
	logic rtc_tick;
	logic [7:0] ticks;
	logic [7:0] ref_ticks;
	wake_t wake_all;
	wake_t wake_ok;
	logic [7:0] next_periph;
	logic periph_tick;

	// Zero-wait slave, always OKAY
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Address phase capture
	assign rd_go = HREADY & HSEL & HTRANS[1] & ~HWRITE;
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (HREADY) begin
			wr_pend <= HSEL & HTRANS[1] & HWRITE;
			wr_addr <= HADDR[7:0];
		end
	end
	assign mode_req = wr_pend && wr_addr == `REG_PWR_CTRL;

	// Read data for the following data phase, unmapped reads as zero
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			HRDATA <= 32'h00000000;
		end else if (rd_go) begin
			unique case (HADDR[7:0])
				`REG_MAIN_SEL: HRDATA <= {29'h0, main_req};
				`REG_SYNTH0: HRDATA <= {16'h0, synth_div[0], 4'h0,
					synth_en[0], synth_ref[0]};
				`REG_SYNTH1: HRDATA <= {16'h0, synth_div[1], 4'h0,
					synth_en[1], synth_ref[1]};
				`REG_MONITOR: HRDATA <= {16'h0, mon_div, 4'h0, mon_halt,
					mon_sel};
				`REG_PWR_CTRL: HRDATA <= {16'h0, keep_mask, 5'h0, mode};
				`REG_BOD_CTRL: HRDATA <= {30'h0, bod_rst_mode, bod_en};
				`REG_RTC_OSC: HRDATA <= {29'h0, os_dpd_en, alarm_flag, rtc_en};
				`REG_STATUS: HRDATA <= {2'h0, wake_cause, 9'h0, BOD_LOW,
					synth_lock, main_cur != main_req, main_cur};
				default: HRDATA <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			main_req <= src_t'(`MAIN_SEL_RESET);
			synth_ref <= '{3'h0, 3'h0};
			synth_en <= 2'b00;
			synth_div <= '{`DIV_RESET, `DIV_RESET};
			mon_sel <= SRC_NONE;
			mon_halt <= 1'b0;
			mon_div <= `DIV_RESET;
			keep_mask <= 8'h00;
			bod_en <= 1'b0;
			bod_rst_mode <= 1'b0;
			rtc_en <= 1'b0;
			os_dpd_en <= 1'b0;
		end else if (wr_pend) begin
			unique case (wr_addr)
				`REG_MAIN_SEL: main_req <= src_t'(HWDATA[2:0]);
				`REG_SYNTH0, `REG_SYNTH1: begin
					synth_ref[wr_addr[3]] <= HWDATA[2:0];
					synth_en[wr_addr[3]] <= HWDATA[`SYNTH_EN_BIT];
					synth_div[wr_addr[3]] <= HWDATA[`DIV_LSB +: 8];
				end
				`REG_MONITOR: begin
					mon_sel <= src_t'(HWDATA[2:0]);
					mon_halt <= HWDATA[`MON_HALT_BIT];
					mon_div <= HWDATA[`DIV_LSB +: 8];
				end
				`REG_PWR_CTRL: keep_mask <= HWDATA[`DIV_LSB +: 8];
				`REG_BOD_CTRL: begin
					bod_en <= HWDATA[`BOD_EN_BIT];
					bod_rst_mode <= HWDATA[`BOD_RST_BIT];
				end
				`REG_RTC_OSC: begin
					rtc_en <= HWDATA[`RTC_EN_BIT];
					os_dpd_en <= HWDATA[`RTC_OSDPD_BIT];
				end
				default: ;
			endcase
		end
	end

	// alarm flag, a new alarm wins over a write-one clear
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			alarm_flag <= 1'b0;
		end else if (lnk.wake_event[`WK_RTC]) begin
			alarm_flag <= 1'b1;
		end else if (wr_pend && wr_addr == `REG_RTC_OSC &&
				HWDATA[`RTC_ALARM_BIT]) begin
			alarm_flag <= 1'b0;
		end
	end

	// divided internal clock, one tick per eight fast ticks
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			fast_cnt <= 3'h0;
		end else if (FAST_OSC_TICK) begin
			fast_cnt <= fast_cnt + 3'h1;
		end
	end
	assign div_tick = FAST_OSC_TICK &&
		fast_cnt == 3'(`FAST_DIV_COUNT - 1);

	assign rtc_tick = RTC_XTAL_TICK & rtc_en;
	// code zero is the tied-off none input
	assign ticks = {synth_out, XTAL_TICK, rtc_tick, LP_OSC_TICK,
		div_tick, FAST_OSC_TICK, 1'b0};
	assign ref_ticks = {3'h0, rtc_tick, LP_OSC_TICK, XTAL_TICK,
		div_tick, 1'b0};

	// Two synthesizers: lock on reference, output by divider
	generate
		for (genvar s = 0; s < 2; s++) begin : g_synth
			logic [$clog2(LOCK_REFS+1)-1:0] lock_cnt;
			logic [7:0] out_cnt;
			always_ff @(posedge CLK_SYS or negedge RESETN) begin
				if (!RESETN) begin
					lock_cnt <= '0;
				end else if (!synth_en[s] || (wr_pend &&
						wr_addr == (s == 0 ? `REG_SYNTH0 : `REG_SYNTH1))) begin
					lock_cnt <= '0;
				end else if (ref_ticks[synth_ref[s]] && !synth_lock[s]) begin
					lock_cnt <= lock_cnt + 1'b1;
				end
			end
			assign synth_lock[s] = lock_cnt == LOCK_REFS[$bits(lock_cnt)-1:0];
			// output rate is CLK_SYS over divider plus one
			always_ff @(posedge CLK_SYS or negedge RESETN) begin
				if (!RESETN) begin
					out_cnt <= 8'h00;
					synth_out[s] <= 1'b0;
				end else if (!synth_lock[s]) begin
					out_cnt <= 8'h00;
					synth_out[s] <= 1'b0;
				end else begin
					synth_out[s] <= out_cnt == synth_div[s];
					out_cnt <= (out_cnt == synth_div[s]) ? 8'h00 :
						out_cnt + 8'h01;
				end
			end
		end
	endgenerate

	// switch after old then new source has ticked
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			main_cur <= src_t'(`MAIN_SEL_RESET);
			seen_old <= 1'b0;
		end else if (main_cur == main_req) begin
			seen_old <= 1'b0;
		end else if (!seen_old) begin
			seen_old <= ticks[main_cur] || main_cur == SRC_NONE;
		end else if (ticks[main_req] || main_req == SRC_NONE) begin
			main_cur <= main_req;
			seen_old <= 1'b0;
		end
	end

	// monitor divider halts holding count, any source
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			mon_cnt <= 8'h00;
			CLOCK_MONITOR_PIN <= 1'b0;
		end else if (!mon_halt && ticks[mon_sel]) begin
			mon_cnt <= (mon_cnt == mon_div) ? 8'h00 : mon_cnt + 8'h01;
			if (mon_cnt == mon_div) begin
				CLOCK_MONITOR_PIN <= ~CLOCK_MONITOR_PIN;
			end
		end
	end

	// brownout to interrupt or reset request
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			lnk.bod_irq <= 1'b0;
			BOD_RESET_REQ <= 1'b0;
		end else begin
			lnk.bod_irq <= bod_en & BOD_LOW & ~bod_rst_mode;
			BOD_RESET_REQ <= bod_en & BOD_LOW & bod_rst_mode;
		end
	end

	// Wake sources qualified by current mode
	always_comb begin
		wake_all = lnk.wake_event;
		wake_all[`WK_RTC] = alarm_flag;
		wake_all[`WK_BOD] = lnk.wake_event[`WK_BOD] | (bod_en & BOD_LOW);
		unique case (mode)
			MODE_SLEEP: wake_ok = wake_all & `WAKE_SLEEP;
			MODE_DEEP_SLEEP: wake_ok = wake_all & `WAKE_DEEP_SLEEP;
			MODE_POWER_DOWN: wake_ok = wake_all & `WAKE_POWER_DOWN;
			MODE_DEEP_PD: wake_ok = wake_all & (`WAKE_DEEP_PD |
				(os_dpd_en ? `WAKE_DPD_OSTIMER : 14'h0000));
			default: wake_ok = 14'h0000;
		endcase
	end

	// single mode, wake returns to active
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			mode <= MODE_ACTIVE;
			wake_cause <= 14'h0000;
		end else if (mode == MODE_ACTIVE) begin
			if (mode_req && HWDATA[2:0] != MODE_ACTIVE &&
					HWDATA[2:0] <= MODE_DEEP_PD) begin
				mode <= pmode_t'(HWDATA[2:0]);
			end
		end else if (|wake_ok) begin
			mode <= MODE_ACTIVE;
			wake_cause <= wake_ok;
		end
	end

	// Peripheral clock allowance per mode
	always_comb begin
		periph_tick = ticks[main_cur];
		unique case (mode)
			MODE_ACTIVE: next_periph = 8'hFF;
			MODE_SLEEP, MODE_DEEP_SLEEP: next_periph = keep_mask;
			MODE_POWER_DOWN: begin
				next_periph = keep_mask & `PERIPH_PD_MASK;
				periph_tick = rtc_tick;
			end
			// rtc domain and optional ostimer survive
			MODE_DEEP_PD: begin
				next_periph = `PERIPH_DPD_MASK |
					(os_dpd_en ? `PERIPH_OSTIMER : 8'h00);
				periph_tick = rtc_tick;
			end
			default: next_periph = 8'h00;
		endcase
	end

	// Gated clocks and power controls to consumers
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			lnk.core_clk_en <= 2'b00;
			lnk.periph_clk_en <= 8'h00;
			lnk.flash_pwr_on <= 1'b1;
			lnk.dcdc_on <= 1'b1;
			lnk.core_pwr_on <= 1'b1;
			lnk.pins_hiz <= 1'b0;
			lnk.primary_core_retain <= 1'b0;
			lnk.power_mode <= MODE_ACTIVE;
		end else begin
			// core ticks only in active mode
			lnk.core_clk_en <= {2{ticks[main_cur] && mode == MODE_ACTIVE}};
			lnk.periph_clk_en <= next_periph & {8{periph_tick}};
			lnk.flash_pwr_on <= mode == MODE_ACTIVE || mode == MODE_SLEEP;
			// converter off in power-down and below
			lnk.dcdc_on <= mode != MODE_POWER_DOWN && mode != MODE_DEEP_PD;
			lnk.core_pwr_on <= mode != MODE_DEEP_PD;
			lnk.pins_hiz <= mode == MODE_DEEP_PD;
			lnk.primary_core_retain <= mode == MODE_POWER_DOWN;
			lnk.power_mode <= mode;
		end
	end
endmodule

// >>> dv/cpm_asserts.sv
/*
 Concurrent checks on the controller-to-consumer link.
 Assumes link signals in the CLK_SYS domain, taken straight from cpm_if.
*/
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_asserts (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Link signals
	input wire logic [1:0] core_clk_en,
	input wire logic [7:0] periph_clk_en,
	input wire logic flash_pwr_on,
	input wire logic dcdc_on,
	input wire logic core_pwr_on,
	input wire logic pins_hiz,
	input wire logic primary_core_retain,
	input wire cpm_pkg::pmode_t power_mode,
	input wire logic bod_irq,
	input wire cpm_pkg::wake_t wake_event
);
	import cpm_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	a_cores_gated: assert property (
		power_mode != MODE_ACTIVE |-> core_clk_en == 2'b00)
		else $error("core clock ran outside active mode");
	a_ds_flash_off: assert property (
		power_mode == MODE_DEEP_SLEEP |-> !flash_pwr_on)
		else $error("flash powered in deep-sleep");
	a_pd_power_off: assert property (
		power_mode == MODE_POWER_DOWN |-> !dcdc_on && !flash_pwr_on)
		else $error("converter or flash on in power-down");
	a_pd_periph: assert property (
		power_mode == MODE_POWER_DOWN
		|-> (periph_clk_en & ~`PERIPH_PD_MASK) == 8'h00)
		else $error("disallowed peripheral clocked in power-down");
	a_pd_retain: assert property (
		power_mode == MODE_POWER_DOWN |-> primary_core_retain)
		else $error("primary core not retained in power-down");
	a_dpd_pins: assert property (
		power_mode == MODE_DEEP_PD |-> pins_hiz && !core_pwr_on)
		else $error("pins driven or core powered in deep power-down");
	a_dpd_periph: assert property (
		power_mode == MODE_DEEP_PD |-> (periph_clk_en & 8'hE7) == 8'h00)
		else $error("disallowed peripheral clocked in deep power-down");
	// any wake but the rtc bit leaves sleep, mode then link copy settle
	a_sleep_wake: assert property (
		power_mode == MODE_SLEEP && (wake_event & 14'h3FEF) != 14'h0000
		|=> ##1 power_mode == MODE_ACTIVE)
		else $error("sleep not left on wake event");
	a_ds_wake: assert property (
		power_mode == MODE_DEEP_SLEEP && (wake_event & 14'h0FEF) != 14'h0000
		|=> ##1 power_mode == MODE_ACTIVE)
		else $error("deep-sleep not left on wake event");
	a_pd_wake: assert property (
		power_mode == MODE_POWER_DOWN && (wake_event & 14'h060A) != 14'h0000
		|=> ##1 power_mode == MODE_ACTIVE)
		else $error("power-down not left on wake event");
	a_dpd_wake: assert property (
		power_mode == MODE_DEEP_PD && wake_event[`WK_WAKEPIN]
		|=> ##1 power_mode == MODE_ACTIVE)
		else $error("deep power-down not left on wake pin");
	// low-power modes only return to active
	a_mode_exit: assert property (
		$changed(power_mode) && $past(power_mode) != MODE_ACTIVE
		|-> power_mode == MODE_ACTIVE)
		else $error("mode changed between low-power modes");

	// Main scenarios reached
	c_sleep: cover property (power_mode == MODE_SLEEP);
	c_pd: cover property (power_mode == MODE_POWER_DOWN);
	c_dpd: cover property (power_mode == MODE_DEEP_PD);
	c_bod: cover property ($rose(bod_irq));
endmodule

// >>> dv/test_clock_and_power_mode_control.sv
/*
 Self-checking bench: both ends joined by cpm_if, registers over AHB-Lite.
 Assumes the designer's register map and a 25 MHz CLK_SYS.
*/
`timescale 1ns/1ps
`include "cpm_defines.svh"
module test_clock_and_power_mode_control;
	import cpm_pkg::*;
	logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp, bod_low, bod_req;
	logic mon_pin, pin_out, pin_oe, bod_seen, prev;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [7:0] cnt, per_t;
	logic [15:0] core0, core1, t0;
	wake_t wake_req;
	wake_t bad[5] = '{14'h0, 14'h0, 14'h1000, 14'h0001, 14'h0008};
	wake_t good[5] = '{14'h0, 14'h2000, 14'h0001, 14'h0200, 14'h1000};
	int fails, cmp_count, m, tg;

	cpm_if cpm_if_inst();
	cpm_controller #(.LOCK_REFS(2)) cpm_controller_inst (.CLK_SYS(clk_sys),
		.RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.FAST_OSC_TICK(cnt[0]), .XTAL_TICK(cnt % 8'h03 == 8'h00),
		.LP_OSC_TICK(cnt % 8'h05 == 8'h00), .RTC_XTAL_TICK(cnt % 8'h07 == 8'h00),
		.BOD_LOW(bod_low), .BOD_RESET_REQ(bod_req),
		.CLOCK_MONITOR_PIN(mon_pin), .lnk(cpm_if_inst));
	cpm_consumer cpm_consumer_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
		.lnk(cpm_if_inst), .WAKE_REQ(wake_req), .PIN_DRIVE(cnt[1]),
		.PIN_DIR(1'b1), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.CORE0_TICKS(core0), .CORE1_TICKS(core1), .PERIPH_TICKED(per_t),
		.BOD_IRQ_SEEN(bod_seen));
	cpm_asserts cpm_asserts_inst (.CLK_SYS(clk_sys), .RESETN(resetn),
		.core_clk_en(cpm_if_inst.core_clk_en),
		.periph_clk_en(cpm_if_inst.periph_clk_en),
		.flash_pwr_on(cpm_if_inst.flash_pwr_on), .dcdc_on(cpm_if_inst.dcdc_on),
		.core_pwr_on(cpm_if_inst.core_pwr_on), .pins_hiz(cpm_if_inst.pins_hiz),
		.primary_core_retain(cpm_if_inst.primary_core_retain),
		.power_mode(cpm_if_inst.power_mode), .bod_irq(cpm_if_inst.bod_irq),
		.wake_event(cpm_if_inst.wake_event));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Source oscillator ticks at unlike rates
	always @(posedge clk_sys) begin
		cnt <= cnt + 8'h01;
	end

	task automatic close_out();
		$display("counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One edge at least, then until ready is sampled high
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk(0, 1, "bus ready timeout");
			close_out();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] msk, exp,
		input string msg);
		int k;
		k = 0;
		do begin
			bus(1'b0, a, 32'h0);
			k++;
		end while ((rd & msk) !== exp && k < 100);
		chk(rd & msk, exp, msg);
		if ((rd & msk) !== exp) begin
			close_out();
		end
	endtask

	task automatic toggles(output int t);
		t = 0;
		prev = mon_pin;
		repeat (40) begin
			@(posedge clk_sys);
			t += int'(mon_pin != prev);
			prev = mon_pin;
		end
	endtask

	task automatic pulse(input wake_t w);
		@(posedge clk_sys);
		wake_req <= w;
		@(posedge clk_sys);
		wake_req <= 14'h0;
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys);
		chk(0, 1, "run timeout");
		close_out();
	end

	// Main sequence
	initial begin
		{resetn, hsel, hwrite, htrans, haddr, hwdata, bod_low} = '0;
		cnt = 8'h00;
		wake_req = 14'h0;
		fails = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		bus(1'b0, `REG_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h2, "main source after reset");
		chk(hresp, 1'b0, "bus response okay");
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("test reset done");
		bus(1'b1, `REG_MAIN_SEL, 32'h0);
		poll(`REG_STATUS, 32'hF, 32'h0, "main to none");
		bus(1'b1, `REG_MAIN_SEL, 32'h1);
		poll(`REG_STATUS, 32'hF, 32'h1, "main to fast");
		bus(1'b1, `REG_RTC_OSC, 32'h1);
		for (m = 1; m <= 4; m++) begin
			bus(1'b1, `REG_SYNTH1, 32'h8 | 32'(m));
			poll(`REG_STATUS, 32'h20, 32'h20, "synth1 lock");
		end
		bus(1'b1, `REG_SYNTH1, 32'h4);
		poll(`REG_STATUS, 32'h20, 32'h0, "synth1 off");
		$display("test sources done");
		bus(1'b1, `REG_SYNTH0, 32'h109);
		poll(`REG_STATUS, 32'h10, 32'h10, "synth0 lock");
		bus(1'b1, `REG_MONITOR, 32'h6);
		toggles(tg);
		chk(32'(tg > 15), 32'h1, "monitor follows synth0");
		bus(1'b1, `REG_MONITOR, 32'hE);
		cyc(4);
		toggles(tg);
		chk(32'(tg), 32'h0, "monitor halted");
		bus(1'b1, `REG_MONITOR, 32'h6);
		toggles(tg);
		chk(32'(tg > 15), 32'h1, "monitor restarted");
		$display("test monitor done");
		bus(1'b1, `REG_BOD_CTRL, 32'h1);
		bod_low <= 1'b1;
		cyc(4);
		chk(bod_seen, 1'b1, "brownout interrupt");
		chk(bod_req, 1'b0, "no reset in interrupt mode");
		bus(1'b1, `REG_BOD_CTRL, 32'h3);
		cyc(3);
		chk(bod_req, 1'b1, "brownout reset request");
		bod_low <= 1'b0;
		bus(1'b1, `REG_BOD_CTRL, 32'h0);
		$display("test brownout done");
		for (m = 1; m <= 4; m++) begin
			bus(1'b1, `REG_PWR_CTRL, 32'hFF00 | 32'(m));
			cyc(3);
			t0 = core0;
			bus(1'b0, `REG_PWR_CTRL, 32'h0);
			chk(rd & 32'h7, 32'(m), "mode entered");
			chk(pin_oe, m != 4, "pin drive in mode");
			if (bad[m] != 14'h0) begin
				pulse(bad[m]);
				cyc(4);
				bus(1'b0, `REG_PWR_CTRL, 32'h0);
				chk(rd & 32'h7, 32'(m), "foreign wake ignored");
			end
			chk(core0, t0, "cores stopped");
			chk(core1, core0, "second core gated alike");
			pulse(good[m]);
			cyc(4);
			bus(1'b0, `REG_PWR_CTRL, 32'h0);
			chk(rd & 32'h7, 32'h0, "woken to active");
			chk(32'(core0 != t0), 32'h1, "cores resumed");
			chk(pin_oe, 1'b1, "pin driven again");
			bus(1'b0, `REG_STATUS, 32'h0);
			chk(rd[29:16], good[m], "wake cause");
		end
		// Alarm flag wakes deep power-down, then write-one clear
		bus(1'b1, `REG_PWR_CTRL, 32'hFF04);
		cyc(3);
		pulse(14'h0010);
		cyc(4);
		bus(1'b0, `REG_PWR_CTRL, 32'h0);
		chk(rd & 32'h7, 32'h0, "alarm wakes deep power-down");
		bus(1'b0, `REG_RTC_OSC, 32'h0);
		chk(rd & 32'h2, 32'h2, "alarm flag set");
		bus(1'b1, `REG_RTC_OSC, 32'h3);
		bus(1'b0, `REG_RTC_OSC, 32'h0);
		chk(rd & 32'h3, 32'h1, "alarm flag cleared");
		bus(1'b0, `REG_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h1, "selection kept");
		$display("test modes done");
		close_out();
	end
endmodule
